//--- verilog/tbt_regs.vh
/*
  register map, field positions, reset values and timing figures of the
  tape blockette transfer engine.
  assumes: included by bare name from the design file; definitions only.
*/
`ifndef TBT_REGS_VH
`define TBT_REGS_VH

// apb byte addresses, one 32-bit word each
`define TBT_ADDR_CTRL 12'h000
`define TBT_ADDR_STATUS 12'h004
`define TBT_ADDR_PROGRESS 12'h008
`define TBT_ADDR_W 12

// control register fields (function word layout)
`define TBT_CTRL_SEND 4
`define TBT_CTRL_RECV 5
`define TBT_CTRL_INSTR_LO 11
`define TBT_CTRL_INSTR_HI 14
`define TBT_CTRL_UNIT_LO 15
`define TBT_CTRL_UNIT_HI 21
`define TBT_CTRL_RESET 32'h0000_0000

// status word fields
`define TBT_ST_ABNORMAL 0
`define TBT_ST_PARITY 5
`define TBT_ST_TIMING 6
`define TBT_ST_BUSY 8
`define TBT_ST_REPORT 9

// blockette geometry
`define TBT_WORDS 24
`define TBT_LAST_WORD 5'h17
`define TBT_CHARS 5
`define TBT_LAST_CHAR 3'h4
`define TBT_LAST_BIT 3'h6
`define TBT_CHAR_W 6
`define TBT_WORD_W 30

// timing
`define TBT_CLK_MHZ 200
`define TBT_LOOKAHEAD_US 250
`define TBT_ACK_LIMIT_US 210
`define TBT_SLOT_US 6
`define TBT_CNT_W 20

`endif

//--- verilog/tbt_blockette.v
/*
  tape blockette transfer engine: moves one 120-character blockette between
  a 30-bit computer channel and a bit-serial tape unit, with parity, channel
  timing checks, a status report and an apb register port.
  assumes: one 200 mhz clock; tape timing strobes and tape data come from an
  asynchronous timing chain and are synchronised here; the computer channel
  handshakes (acks, output word) are on this clock.
*/
// Notes on behaviour
// - a blockette is 120 characters, carried as 24 thirty-bit words
// - tape character is six data bits plus one parity bit, odd ones
// - parity added on send; checked and stripped on receive
// - word holds five characters, character 0 in bits 0..5 upward
// - first tape line is last buffer word's character 0 (bits 0..5)
// - start at once unless a marker is due within about 250 us
// - send: issue instruction, raise word request, latch word on acknowledge
// - move latched word to shifter and request the next word
// - sending starts at first write slot after the sync marker
// - characters 0..4 in order, low bit first, parity in slot 7
// - one serial bit per six microsecond slot
// - ones and zeros go out as pulses on two lines
// - after 24 words end at next marker, interrupt, wait input acknowledge
// - late output word aborts with timing fault, abnormal and interrupt
// - receive: issue instruction, first bit in first read slot after marker
// - incoming characters 0..4 checked, stripped, assembled into 30 bits
// - assembled word goes to holding register and input request
// - receive line: pulse in slot is one, no pulse is zero
// - unacknowledged input word when next is ready aborts with timing fault
// - parity failure sets parity and abnormal bits, transfer still finishes
// - manual clear resets engine and on-line units; off-line units excluded
// - status bit 6 timing, bit 5 parity, bit 0 abnormal summary
`timescale 1ns/100ps
`include "tbt_regs.vh"

module tbt_blockette #(
  parameter [`TBT_CNT_W-1:0] LOOKAHEAD_CYC = `TBT_LOOKAHEAD_US * `TBT_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TBT_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // computer output channel
  input wire [`TBT_WORD_W-1:0] out_word,
  input wire out_ack,
  output reg out_req,
  // computer input channel and status-report interrupt
  output reg [`TBT_WORD_W-1:0] in_word,
  output reg in_req,
  input wire in_ack,
  output reg status_intr,
  // tape timing chain (asynchronous)
  input wire sync_marker_pulse,
  input wire [6:0] write_bit_slot,
  input wire [6:0] read_bit_slot,
  // tape data and control
  input wire tape_rd_one,
  output reg tape_wr_one,
  output reg tape_wr_zero,
  output reg tape_cmd_strobe,
  output reg [3:0] tape_cmd,
  output reg [6:0] tape_unit_sel,
  // maintenance panel
  input wire manual_clear,
  input wire [6:0] unit_online,
  output reg [6:0] tape_unit_clear
);

  // states
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_DEFER = 4'h1;
  localparam [3:0] ST_ISSUE = 4'h2;
  localparam [3:0] ST_SEND_SYNC = 4'h3;
  localparam [3:0] ST_SEND_RUN = 4'h4;
  localparam [3:0] ST_RECV_SYNC = 4'h5;
  localparam [3:0] ST_RECV_RUN = 4'h6;
  localparam [3:0] ST_END_SYNC = 4'h7;
  localparam [3:0] ST_REPORT = 4'h8;

  // synchroniser stages: first stage feeds only the second
  reg [15:0] sync1_reg;
  reg [15:0] sync2_reg;
  reg [1:0] aux1_reg;
  reg [1:0] aux2_reg;
  wire marker;
  wire [6:0] wslot;
  wire [6:0] rslot;
  wire rd_one;
  wire clr_pin;
  wire clr;

  // state and datapath
  reg [3:0] state_reg;
  reg dir_send_reg;
  reg [31:0] ctrl_reg;
  reg [`TBT_WORD_W-1:0] hold_reg;
  reg hold_full_reg;
  reg [`TBT_WORD_W-1:0] shift_reg;
  reg shift_full_reg;
  reg [`TBT_CHAR_W-1:0] char_reg;
  reg [2:0] bit_idx_reg;
  reg [2:0] char_idx_reg;
  reg [4:0] word_cnt_reg;
  reg parity_fault_reg;
  reg timing_fault_reg;
  reg [`TBT_CNT_W-1:0] since_reg;
  reg [`TBT_CNT_W-1:0] period_reg;
  wire [`TBT_CNT_W-1:0] remain;
  wire marker_near;
  wire abnormal;
  wire [31:0] status_word;
  wire busy;
  wire wr_access;
  wire start_send;
  wire start_recv;
  wire out_take;
  wire out_bit;
  wire slot_w;
  wire slot_r;
  wire last_word;

  // two-flop synchronisers for everything that comes from the timing chain
  always @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      aux1_reg <= 2'h0;
      aux2_reg <= 2'h0;
    end else begin
      sync1_reg <= {tape_rd_one, read_bit_slot, write_bit_slot, sync_marker_pulse};
      sync2_reg <= sync1_reg;
      aux1_reg <= {1'b0, manual_clear};
      aux2_reg <= aux1_reg;
    end
  end

  // strobes stay one cycle wide after the two flops
  assign marker = sync2_reg[0];
  assign wslot = sync2_reg[7:1];
  assign rslot = sync2_reg[14:8];
  assign rd_one = sync2_reg[15];
  assign clr_pin = aux2_reg[0];
  assign clr = rst | clr_pin; // manual clear acts as a full reset

  // marker phase tracking: period learnt from the last two markers
  always @(posedge clk) begin
    if (clr) begin
      since_reg <= {`TBT_CNT_W{1'b0}};
      period_reg <= {`TBT_CNT_W{1'b0}};
    end else if (marker) begin
      since_reg <= {`TBT_CNT_W{1'b0}};
      period_reg <= since_reg;
    end else if (since_reg != {`TBT_CNT_W{1'b1}}) begin
      since_reg <= since_reg + 1'b1;
    end
  end

  // unknown period (zero) never defers; a late start risks the first word
  assign remain = period_reg - since_reg;
  assign marker_near = (period_reg != {`TBT_CNT_W{1'b0}}) &&
                       (since_reg <= period_reg) && (remain < LOOKAHEAD_CYC);

  // apb decode: zero wait states, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != `TBT_ADDR_CTRL) &
                   (paddr != `TBT_ADDR_STATUS) & (paddr != `TBT_ADDR_PROGRESS);
  assign wr_access = psel & penable & pwrite & (paddr == `TBT_ADDR_CTRL);
  assign busy = (state_reg != ST_IDLE);
  // a command written while busy is ignored; send wins if both bits are set
  assign start_send = wr_access & ~busy & pwdata[`TBT_CTRL_SEND];
  assign start_recv = wr_access & ~busy & ~pwdata[`TBT_CTRL_SEND] & pwdata[`TBT_CTRL_RECV];

  // abnormal summary follows the fault bits
  assign abnormal = parity_fault_reg | timing_fault_reg;
  assign status_word = {22'h000000, status_intr, busy, 1'b0, timing_fault_reg,
                        parity_fault_reg, 4'h0, abnormal};

  // read data registered at the setup phase so it is stable in access
  always @(posedge clk) begin
    if (clr) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `TBT_ADDR_CTRL: prdata <= ctrl_reg;
        `TBT_ADDR_STATUS: prdata <= status_word;
        `TBT_ADDR_PROGRESS: prdata <= {27'h0000000, word_cnt_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // serial bit selection for the send and receive sides
  assign slot_w = wslot[bit_idx_reg]; // slot k carries bit k
  assign slot_r = rslot[bit_idx_reg];
  // bits 0..5 low first, then odd parity in slot 7
  assign out_bit = (bit_idx_reg == `TBT_LAST_BIT) ? ~(^char_reg) : char_reg[bit_idx_reg];
  assign last_word = (word_cnt_reg == `TBT_LAST_WORD);
  assign out_take = out_req & out_ack & ~hold_full_reg;

  // main sequencer
  always @(posedge clk) begin
    if (clr) begin
      state_reg <= ST_IDLE;
      dir_send_reg <= 1'b0;
      ctrl_reg <= `TBT_CTRL_RESET;
      hold_reg <= {`TBT_WORD_W{1'b0}};
      hold_full_reg <= 1'b0;
      shift_reg <= {`TBT_WORD_W{1'b0}};
      shift_full_reg <= 1'b0;
      char_reg <= {`TBT_CHAR_W{1'b0}};
      bit_idx_reg <= 3'h0;
      char_idx_reg <= 3'h0;
      word_cnt_reg <= 5'h00;
      parity_fault_reg <= 1'b0;
      timing_fault_reg <= 1'b0;
      out_req <= 1'b0;
      in_req <= 1'b0;
      in_word <= {`TBT_WORD_W{1'b0}};
      status_intr <= 1'b0;
      tape_wr_one <= 1'b0;
      tape_wr_zero <= 1'b0;
      tape_cmd_strobe <= 1'b0;
      tape_cmd <= 4'h0;
      tape_unit_sel <= 7'h00;
    end else begin
      // pulse outputs default low
      tape_wr_one <= 1'b0;
      tape_wr_zero <= 1'b0;
      tape_cmd_strobe <= 1'b0;
      if (start_send | start_recv) begin
        ctrl_reg <= pwdata;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start_send | start_recv) begin
            dir_send_reg <= start_send;
            parity_fault_reg <= 1'b0;
            timing_fault_reg <= 1'b0;
            word_cnt_reg <= 5'h00;
            hold_full_reg <= 1'b0;
            shift_full_reg <= 1'b0;
            // defer past a marker that is about to arrive
            state_reg <= marker_near ? ST_DEFER : ST_ISSUE;
          end
        end
        ST_DEFER: begin
          if (marker) begin
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          // instruction goes only to an on-line unit
          tape_cmd_strobe <= 1'b1;
          tape_cmd <= ctrl_reg[`TBT_CTRL_INSTR_HI:`TBT_CTRL_INSTR_LO];
          tape_unit_sel <= ctrl_reg[`TBT_CTRL_UNIT_HI:`TBT_CTRL_UNIT_LO] & unit_online;
          bit_idx_reg <= 3'h0;
          char_idx_reg <= 3'h0;
          if (dir_send_reg) begin
            out_req <= 1'b1; // request in the same cycle as the instruction
            state_reg <= ST_SEND_SYNC;
          end else begin
            state_reg <= ST_RECV_SYNC;
          end
        end
        ST_SEND_SYNC: begin
          // latch the word and drop the request
          if (out_take) begin
            hold_reg <= out_word;
            hold_full_reg <= 1'b1;
            out_req <= 1'b0;
          end
          // holding to shifter, then ask for the next word
          if (hold_full_reg & ~shift_full_reg) begin
            shift_reg <= hold_reg;
            shift_full_reg <= 1'b1;
            char_reg <= hold_reg[`TBT_CHAR_W-1:0];
            hold_full_reg <= 1'b0;
            out_req <= 1'b1;
          end
          if (marker) begin
            if (shift_full_reg) begin
              state_reg <= ST_SEND_RUN; // first bit in next write slot 1
            end else begin
              // no word by the time serialising must start
              timing_fault_reg <= 1'b1;
              out_req <= 1'b0;
              state_reg <= ST_REPORT;
            end
          end
        end
        ST_SEND_RUN: begin
          if (out_take) begin
            hold_reg <= out_word;
            hold_full_reg <= 1'b1;
            out_req <= 1'b0;
          end
          if (slot_w) begin
            tape_wr_one <= out_bit; // two-line pulse coding
            tape_wr_zero <= ~out_bit;
            if (bit_idx_reg != `TBT_LAST_BIT) begin
              bit_idx_reg <= bit_idx_reg + 1'b1;
            end else begin
              bit_idx_reg <= 3'h0;
              if (char_idx_reg != `TBT_LAST_CHAR) begin
                // next character in ascending order
                char_idx_reg <= char_idx_reg + 1'b1;
                char_reg <= shift_reg[char_idx_reg * `TBT_CHAR_W + `TBT_CHAR_W +: `TBT_CHAR_W];
              end else begin
                char_idx_reg <= 3'h0;
                if (last_word) begin
                  word_cnt_reg <= word_cnt_reg + 1'b1;
                  out_req <= 1'b0;
                  state_reg <= ST_END_SYNC;
                end else if (hold_full_reg | out_take) begin
                  // next word to the shifter, request another
                  shift_reg <= hold_full_reg ? hold_reg : out_word;
                  char_reg <= hold_full_reg ? hold_reg[`TBT_CHAR_W-1:0] :
                              out_word[`TBT_CHAR_W-1:0];
                  hold_full_reg <= 1'b0;
                  word_cnt_reg <= word_cnt_reg + 1'b1; // buffer word 23 - count
                  out_req <= 1'b1;
                end else begin
                  // computer was too late with the next word
                  timing_fault_reg <= 1'b1;
                  out_req <= 1'b0;
                  state_reg <= ST_REPORT;
                end
              end
            end
          end
        end
        ST_RECV_SYNC: begin
          if (marker) begin
            state_reg <= ST_RECV_RUN; // first bit in next read slot 1
          end
        end
        ST_RECV_RUN: begin
          // computer has taken the word: remove data and request
          if (in_req & in_ack) begin
            in_req <= 1'b0;
            in_word <= {`TBT_WORD_W{1'b0}};
          end
          if (slot_r) begin
            if (bit_idx_reg != `TBT_LAST_BIT) begin
              char_reg[bit_idx_reg] <= rd_one;
              bit_idx_reg <= bit_idx_reg + 1'b1;
            end else begin
              bit_idx_reg <= 3'h0;
              // odd parity check, flag kept but transfer goes on
              if (~(^{rd_one, char_reg})) begin
                parity_fault_reg <= 1'b1;
              end
              // stripped character into its field
              shift_reg[char_idx_reg * `TBT_CHAR_W +: `TBT_CHAR_W] <= char_reg;
              if (char_idx_reg != `TBT_LAST_CHAR) begin
                char_idx_reg <= char_idx_reg + 1'b1;
              end else begin
                char_idx_reg <= 3'h0;
                if (in_req & ~in_ack) begin
                  // previous word still unacknowledged
                  timing_fault_reg <= 1'b1;
                  in_req <= 1'b0;
                  in_word <= {`TBT_WORD_W{1'b0}};
                  state_reg <= ST_REPORT;
                end else begin
                  // assembled word onto the input channel
                  in_word <= {char_reg, shift_reg[`TBT_WORD_W-`TBT_CHAR_W-1:0]};
                  in_req <= 1'b1;
                  word_cnt_reg <= word_cnt_reg + 1'b1;
                  if (last_word) begin
                    state_reg <= ST_END_SYNC;
                  end
                end
              end
            end
          end
        end
        ST_END_SYNC: begin
          if (in_req & in_ack) begin
            in_req <= 1'b0;
            in_word <= {`TBT_WORD_W{1'b0}};
          end
          // the transfer ends at the marker after the last word
          if (marker) begin
            if (in_req & ~in_ack) begin
              timing_fault_reg <= 1'b1; // last input word never taken
              in_req <= 1'b0;
              in_word <= {`TBT_WORD_W{1'b0}};
            end
            state_reg <= ST_REPORT;
          end
        end
        ST_REPORT: begin
          // status word rides the input channel with the interrupt
          status_intr <= 1'b1;
          in_word <= status_word[`TBT_WORD_W-1:0];
          if (status_intr & in_ack) begin
            status_intr <= 1'b0; // available again on input acknowledge
            in_word <= {`TBT_WORD_W{1'b0}};
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // manual clear is forwarded only to units switched on-line
  always @(posedge clk) begin
    if (rst) begin
      tape_unit_clear <= 7'h00;
    end else begin
      tape_unit_clear <= clr_pin ? unit_online : 7'h00;
    end
  end

endmodule

//--- tb/tbt_blockette_props.sv
/*
  port checker for the blockette transfer engine.
  assumes: bound to tbt_blockette; one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module tbt_blockette_props (
  // clock and reset
  input wire clk,
  input wire rst,
  // computer channels
  input wire out_req,
  input wire out_ack,
  input wire in_req,
  input wire in_ack,
  input wire status_intr,
  input wire [29:0] in_word,
  // tape side and panel
  input wire [6:0] write_bit_slot,
  input wire tape_wr_one,
  input wire tape_wr_zero,
  input wire manual_clear,
  input wire [6:0] unit_online,
  input wire [6:0] tape_unit_clear
);
  logic [3:0] since_slot;

  // cycles since the last write slot strobe, saturating so idle time cannot wrap
  always @(posedge clk) begin
    if (rst)
      since_slot <= 4'hf;
    else if (|write_bit_slot)
      since_slot <= 4'h0;
    else if (since_slot != 4'hf)
      since_slot <= since_slot + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_lines_exclusive: assert property (!(tape_wr_one && tape_wr_zero))
    else $error("both tape write lines pulsed");
  a_pulse_single: assert property ((tape_wr_one || tape_wr_zero) |=> !(tape_wr_one || tape_wr_zero))
    else $error("tape write pulse longer than one cycle");
  a_slot_aligned: assert property ((tape_wr_one || tape_wr_zero) |-> since_slot inside {[1:5]})
    else $error("tape write pulse not tied to a write slot");
  a_out_accept: assert property (out_req && out_ack |=> !out_req)
    else $error("output request kept after acknowledge");
  a_in_accept: assert property (in_req && in_ack |=> !in_req)
    else $error("input request kept after acknowledge");
  a_intr_release: assert property (status_intr && in_ack |=> !status_intr)
    else $error("interrupt kept after acknowledge");
  a_abnormal_sum: assert property (status_intr && (in_word[5] || in_word[6]) |-> in_word[0])
    else $error("abnormal summary bit missing");
  a_unit_clear: assert property (manual_clear [*5] |-> tape_unit_clear == unit_online)
    else $error("on-line units not cleared");

  c_report: cover property (status_intr && in_ack);
  c_timing: cover property (status_intr && in_word[6]);
  c_parity: cover property (status_intr && in_word[5]);
endmodule

bind tbt_blockette tbt_blockette_props props_u (.clk(clk), .rst(rst), .out_req(out_req),
  .out_ack(out_ack), .in_req(in_req), .in_ack(in_ack), .status_intr(status_intr),
  .in_word(in_word), .write_bit_slot(write_bit_slot), .tape_wr_one(tape_wr_one),
  .tape_wr_zero(tape_wr_zero), .manual_clear(manual_clear), .unit_online(unit_online),
  .tape_unit_clear(tape_unit_clear));

//--- tb/tbt_tape_model.sv
/*
  timing chain and tape unit model: marker and slot strobes, read data stream.
  assumes: slot period shortened to SLOT cycles; marker period a whole number
  of seven-slot characters.
*/
`timescale 1ns/100ps
module tbt_tape_model #(
  parameter int SLOT = 10,
  parameter int MARK = 9100
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // tape unit control
  input wire tape_cmd_strobe,
  input wire rd_mode,
  input wire [4:0] rd_bad,
  input wire [29:0] rd_word,
  output logic [4:0] rd_index,
  // timing chain and data
  output logic sync_marker_pulse,
  output logic [6:0] write_bit_slot,
  output logic [6:0] read_bit_slot,
  output logic tape_rd_one
);
  int ph, mk;
  logic armed, streaming;
  logic [2:0] bit_n, ch_n;
  logic [5:0] ch;
  logic par;

  // free-running phase counters for slots and marker
  always @(posedge clk) begin
    if (rst) begin
      ph <= 0;
      mk <= 0;
    end else begin
      ph <= (ph == 7 * SLOT - 1) ? 0 : ph + 1;
      mk <= (mk == MARK - 1) ? 0 : mk + 1;
    end
  end

  // one-cycle strobes; marker lands just before a first write slot
  always @* begin
    sync_marker_pulse = !rst && (mk == MARK - 5);
    for (int k = 0; k < 7; k++) begin
      write_bit_slot[k] = !rst && (ph == k * SLOT);
      read_bit_slot[k] = !rst && (ph == k * SLOT + SLOT / 2);
    end
  end

  // odd parity, spoiled on character 0 of the chosen word to provoke a fault
  assign ch = rd_word[ch_n * 6 +: 6];
  assign par = ~^ch ^ (rd_bad == rd_index && ch_n == 3'h0);
  // a pulse only in the matching read slot, so a zero is silence
  assign tape_rd_one = streaming && read_bit_slot[bit_n] && (bit_n == 3'h6 ? par : ch[bit_n]);

  // arm on instruction, start after marker, low bit first, chars 0..4 in order
  always @(posedge clk) begin
    if (rst) begin
      armed <= 1'b0;
      streaming <= 1'b0;
      bit_n <= 3'h0;
      ch_n <= 3'h0;
      rd_index <= 5'h00;
    end else if (tape_cmd_strobe && rd_mode) begin
      armed <= 1'b1;
    end else if (sync_marker_pulse && armed) begin
      armed <= 1'b0;
      streaming <= 1'b1;
      bit_n <= 3'h0;
      ch_n <= 3'h0;
      rd_index <= 5'h00;
    end else if (streaming && read_bit_slot[bit_n]) begin
      bit_n <= (bit_n == 3'h6) ? 3'h0 : bit_n + 3'h1;
      if (bit_n == 3'h6) begin
        ch_n <= (ch_n == 3'h4) ? 3'h0 : ch_n + 3'h1;
        if (ch_n == 3'h4) begin
          rd_index <= rd_index + 5'h01;
          streaming <= (rd_index != 5'h17);
        end
      end
    end
  end
endmodule

//--- tb/tape_blockette_transfer_test.sv
/*
  self-checking bench for the blockette transfer engine.
  assumes: tbt_tape_model drives timing strobes and read data; the bench is
  the computer channel and the apb master.
*/
`timescale 1ns/100ps
`include "tbt_regs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end

module tape_blockette_transfer_test;
  localparam logic [31:0] CMD_SEND = 32'h0000_9010;
  localparam logic [31:0] CMD_RECV = 32'h0000_9020;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [`TBT_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [29:0] out_word, in_word, rd_word, ch;
  logic out_ack, out_req, in_req, in_ack, status_intr, sync_marker_pulse, tape_rd_one;
  logic tape_wr_one, tape_wr_zero, tape_cmd_strobe, manual_clear, rd_mode;
  logic [6:0] write_bit_slot, read_bit_slot, tape_unit_sel, unit_online, tape_unit_clear;
  logic [3:0] tape_cmd;
  logic [4:0] rd_index, rd_bad;
  logic wr_q[$];
  int n_fail, check_count, cyc, mark_cyc, cmd_cyc, t0;

  function automatic logic [29:0] pat(input int n);
    pat = 30'h15a5_a5a5 ^ (30'h0123_4567 * 30'(n));
  endfunction

  tbt_blockette #(.LOOKAHEAD_CYC(20'd200)) dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_word(out_word), .out_ack(out_ack),
    .out_req(out_req), .in_word(in_word), .in_req(in_req), .in_ack(in_ack),
    .status_intr(status_intr), .sync_marker_pulse(sync_marker_pulse),
    .write_bit_slot(write_bit_slot), .read_bit_slot(read_bit_slot), .tape_rd_one(tape_rd_one),
    .tape_wr_one(tape_wr_one), .tape_wr_zero(tape_wr_zero), .tape_cmd_strobe(tape_cmd_strobe),
    .tape_cmd(tape_cmd), .tape_unit_sel(tape_unit_sel), .manual_clear(manual_clear),
    .unit_online(unit_online), .tape_unit_clear(tape_unit_clear));
  tbt_tape_model tm_u (.clk(clk), .rst(rst), .tape_cmd_strobe(tape_cmd_strobe),
    .rd_mode(rd_mode), .rd_bad(rd_bad), .rd_word(rd_word), .rd_index(rd_index),
    .sync_marker_pulse(sync_marker_pulse), .write_bit_slot(write_bit_slot),
    .read_bit_slot(read_bit_slot), .tape_rd_one(tape_rd_one));
  assign rd_word = pat(rd_index);

  // clock source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // cycle count, event times, tape bits, hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sync_marker_pulse)
      mark_cyc <= cyc;
    if (tape_cmd_strobe)
      cmd_cyc <= cyc;
    if (tape_wr_one || tape_wr_zero)
      wr_q.push_back(tape_wr_one);
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // computer side of a send: one word per request
  task automatic send_words(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      while (out_req !== 1'b1) @(posedge clk);
      out_word <= pat(i);
      out_ack <= 1'b1;
      @(posedge clk);
      out_ack <= 1'b0;
      out_word <= ~pat(i);
    end
  endtask

  // computer side of a receive: check and acknowledge each word
  task automatic recv_words(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      while (in_req !== 1'b1) @(posedge clk);
      `CHK("in_word", pat(i), in_word)
      in_ack <= 1'b1;
      @(posedge clk);
      in_ack <= 1'b0;
    end
  endtask

  // take the status report
  task automatic report(input logic [2:0] e);
    logic [2:0] s;
    @(posedge clk);
    while (status_intr !== 1'b1) @(posedge clk);
    s = {in_word[`TBT_ST_TIMING], in_word[`TBT_ST_PARITY], in_word[`TBT_ST_ABNORMAL]};
    `CHK("status_word", e, s)
    in_ack <= 1'b1;
    @(posedge clk);
    in_ack <= 1'b0;
    @(posedge clk);
    `CHK("intr_released", 1'b0, status_intr)
  endtask

  // scenario sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, out_ack, in_ack, manual_clear, rd_mode} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    out_word = 30'h0;
    unit_online = 7'h55;
    rd_bad = 5'h1f;
    {n_fail, check_count, cyc, mark_cyc, cmd_cyc} = {5{32'sd0}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values; the unmapped word errs
    for (int a = 0; a < 4; a++) begin
      apb(1'b0, 12'(4 * a), 32'h0);
      `CHK("reg_reset", 32'h0, rdv)
      `CHK("slverr", a == 3, err)
    end
    // full send, with a second command refused while busy
    t0 = cyc;
    apb(1'b1, `TBT_ADDR_CTRL, CMD_SEND);
    apb(1'b1, `TBT_ADDR_CTRL, CMD_RECV);
    apb(1'b0, `TBT_ADDR_CTRL, 32'h0);
    `CHK("ctrl_locked", CMD_SEND, rdv)
    apb(1'b0, `TBT_ADDR_STATUS, 32'h0);
    `CHK("busy", 1'b1, rdv[`TBT_ST_BUSY])
    `CHK("cmd_prompt", 1'b1, cmd_cyc > t0 && cmd_cyc - t0 < 20)
    `CHK("cmd_code", 4'h2, tape_cmd)
    `CHK("unit_sel", 7'h01, tape_unit_sel)
    wr_q.delete();
    send_words(24);
    report(3'b000);
    `CHK("bit_count", 840, wr_q.size())
    for (int n = 0; n < 24; n++)
      for (int c = 0; c < 5; c++)
        for (int b = 0; b < 7; b++) begin
          ch = pat(n) >> (6 * c);
          `CHK("tape_bit", b == 6 ? ~^ch[5:0] : ch[b], wr_q[35 * n + 7 * c + b])
        end
    apb(1'b0, `TBT_ADDR_PROGRESS, 32'h0);
    `CHK("progress", 32'd24, rdv)
    // receive, parity fault in word 3
    rd_mode <= 1'b1;
    rd_bad <= 5'd3;
    apb(1'b1, `TBT_ADDR_CTRL, CMD_RECV);
    recv_words(24);
    report(3'b011);
    // late output word, then unacknowledged input word
    rd_bad <= 5'h1f;
    rd_mode <= 1'b0;
    apb(1'b1, `TBT_ADDR_CTRL, CMD_SEND);
    report(3'b101);
    rd_mode <= 1'b1;
    apb(1'b1, `TBT_ADDR_CTRL, CMD_RECV);
    report(3'b101);
    // command near a marker waits for it, then a manual clear
    rd_mode <= 1'b0;
    @(posedge clk);
    while (sync_marker_pulse !== 1'b1) @(posedge clk);
    repeat (8950) @(posedge clk);
    t0 = cyc;
    apb(1'b1, `TBT_ADDR_CTRL, CMD_SEND);
    while (tape_cmd_strobe !== 1'b1) @(posedge clk);
    `CHK("deferred", 1'b1, mark_cyc > t0)
    manual_clear <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("unit_clear", unit_online, tape_unit_clear)
    manual_clear <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("req_cleared", 1'b0, out_req)
    apb(1'b0, `TBT_ADDR_STATUS, 32'h0);
    `CHK("idle_after_clear", 32'h0, rdv)
    tally_and_finish();
  end
endmodule
